//--- src/lsp_line_supervisor.sv
// Line supervision: crossing timeout, period, dip, peaks and interrupt flags
`timescale 1ns/1ps
`default_nettype none
module lsp_line_supervisor #(
  parameter int unsigned TMO_DIV  = lsp_pkg::TMO_DIV,
  parameter int unsigned PEAK_DIV = lsp_pkg::PEAK_DIV
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire logic [15:0]                v_filt_i,
  input  wire logic [23:0]                v_sample_i,
  input  wire logic [23:0]                i_sample_i,
  input  wire logic                       sample_valid_i,
  input  wire logic                       supply_low_i,
  input  wire logic                       dip_alert_disable_i,
  input  wire logic [lsp_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic                       reg_wr_i,
  input  wire logic [23:0]                reg_wdata_i,
  input  wire logic                       reg_rd_i,
  input  wire logic                       reg_done_i,
  output var  logic [23:0]                reg_rdata_o,
  output var  logic                       irq_n_o,
  output var  logic                       dip_alert_n_o,
  output var  logic                       crossing_indicator_o,
  output var  logic                       energy_hold_o
);
  localparam logic [6:0] TMO_LAST = 7'(TMO_DIV - 1);
  localparam logic [1:0] PK_LAST  = 2'(PEAK_DIV - 1);

  typedef struct packed {
    lsp_pkg::lsp_rd_t rd;
    logic [6:0]       div_tmo;
    logic [1:0]       div_pk;
    logic [11:0]      tmo_cnt;
    logic [11:0]      tmo_reload;
    logic             v_pos;
    logic [18:0]      per_cnt;
    logic             per_valid;
    logic [15:0]      period;
    logic [7:0]       dip_lvl;
    logic [7:0]       dip_cyc;
    logic [7:0]       dip_run;
    logic             dip_below;
    logic             dip_alert;
    logic             alert_n;
    logic [7:0]       vpk_lvl;
    logic [7:0]       ipk_lvl;
    logic [23:0]      voltage_peak_hold;
    logic [23:0]      current_peak_hold;
    logic [15:0]      mask;
    logic [15:0]      status;
    logic [23:0]      rdata;
    logic [1:0]       sup_sync;
  } lsp_state_t;

  lsp_state_t s_q, s_d;

  function automatic logic [23:0] abs24(input logic [23:0] x);
    abs24 = x[23] ? 24'(-x) : x;
  endfunction : abs24

  logic [15:0] v_abs16;
  logic [23:0] v_abs, i_abs;
  logic [7:0]  v_dip_byte, v_pk_byte, i_pk_byte;
  logic        tmo_tick, pk_tick, zx_ev, cyc_end, tmo_ev;
  logic        dip_ev, vpk_ev, ipk_ev;
  logic [15:0] events;
  logic [15:0] meas;
  logic [16:0] per_diff;
  logic [15:0] per_step;
  logic        supply_low;
  logic        stat_rd, vclr, iclr;

  always_comb begin
    v_abs16    = v_filt_i[15] ? 16'(-v_filt_i) : v_filt_i;
    v_abs      = abs24(v_sample_i);
    i_abs      = abs24(i_sample_i);
    v_dip_byte = v_abs16[14:7];
    v_pk_byte  = v_abs[22:15];
    i_pk_byte  = i_abs[22:15];
    supply_low = s_q.sup_sync[1];
    tmo_tick   = (s_q.div_tmo == TMO_LAST);
    pk_tick    = (s_q.div_pk == PK_LAST);
    // Sign change of the filtered voltage, either direction
    zx_ev      = sample_valid_i && (s_q.v_pos == v_filt_i[15]);
    cyc_end    = zx_ev && !v_filt_i[15];
    tmo_ev     = !zx_ev && tmo_tick && (s_q.tmo_cnt == 12'h001);
    dip_ev     = 1'b0;
    vpk_ev     = sample_valid_i && (v_pk_byte > s_q.vpk_lvl);
    ipk_ev     = sample_valid_i && (i_pk_byte > s_q.ipk_lvl);
    if (cyc_end && s_q.dip_below && !s_q.dip_alert &&
        (s_q.dip_run + 8'h01 == s_q.dip_cyc - 8'h01)) begin
      dip_ev = 1'b1;
    end
    events = 16'h0000;
    events[lsp_pkg::ST_TIMEOUT] = tmo_ev;
    events[lsp_pkg::ST_DIP]     = dip_ev;
    events[lsp_pkg::ST_CROSS]   = zx_ev;
    events[lsp_pkg::ST_VPK]     = vpk_ev;
    events[lsp_pkg::ST_IPK]     = ipk_ev;
    // Saturate so the MSB of the period stays clear
    meas     = (s_q.per_cnt[18:18] != 1'b0) ? 16'h7fff
               : {1'b0, s_q.per_cnt[17:lsp_pkg::PER_SHIFT]};
    per_diff = {1'b0, meas} - {1'b0, s_q.period};
    per_step = 16'($signed(per_diff) >>> lsp_pkg::PER_FILT_K);
    // Plain shift leaves a dead band of up to seven counts
    if ((per_step == 16'h0000) && (per_diff != 17'h00000)) begin
      per_step = per_diff[16] ? 16'hffff : 16'h0001;
    end
    stat_rd  = reg_rd_i && (reg_addr_i == lsp_pkg::A_STAT_CLR);
    vclr     = reg_done_i && (reg_addr_i == lsp_pkg::A_VOLTAGE_PEAK_HOLD_CLR);
    iclr     = reg_done_i && (reg_addr_i == lsp_pkg::A_CURRENT_PEAK_HOLD_CLR);
  end

  always_comb begin
    s_d = s_q;
    s_d.sup_sync = {s_q.sup_sync[0], supply_low_i};
    s_d.div_tmo  = tmo_tick ? 7'h00 : 7'(s_q.div_tmo + 7'h01);
    s_d.div_pk   = pk_tick ? 2'h0 : 2'(s_q.div_pk + 2'h1);
    if (sample_valid_i) begin
      s_d.v_pos = !v_filt_i[15];
    end

    // Crossing timeout
    if (zx_ev) begin
      s_d.tmo_cnt = s_q.tmo_reload;
    end else if (tmo_tick && s_q.tmo_cnt != 12'h000) begin
      s_d.tmo_cnt = 12'(s_q.tmo_cnt - 12'h001);
    end

    // Period over one full cycle, first result loaded directly
    s_d.per_cnt = (s_q.per_cnt[18:18] != 1'b0) ? s_q.per_cnt : 19'(s_q.per_cnt + 19'h1);
    if (cyc_end) begin
      s_d.per_cnt   = 19'h1;
      s_d.per_valid = 1'b1;
      if (!s_q.per_valid) begin
        s_d.period = meas;
      end else begin
        // Slow average trades settling time for a steady reading
        s_d.period = 16'(s_q.period + per_step);
      end
    end
    s_d.period[15] = 1'b0;

    // Dip tracking per line cycle
    if (sample_valid_i && !(s_q.dip_lvl > v_dip_byte)) begin
      s_d.dip_below = 1'b0;
    end
    if (s_q.dip_alert && sample_valid_i && (v_dip_byte > s_q.dip_lvl)) begin
      s_d.dip_alert = 1'b0;
      s_d.dip_run   = 8'h00;
    end
    if (cyc_end) begin
      s_d.dip_below = 1'b1;
      if (!s_q.dip_below) begin
        s_d.dip_run = 8'h00;
      end else if (s_q.dip_run != 8'hff) begin
        s_d.dip_run = 8'(s_q.dip_run + 8'h01);
      end
      if (dip_ev) begin
        s_d.dip_alert = 1'b1;
      end
    end
    s_d.alert_n = !((s_q.dip_alert && !dip_alert_disable_i) ||
                    (s_q.tmo_cnt == 12'h000 && !dip_alert_disable_i) ||
                    supply_low);

    // Peak holds at clock/4
    if (pk_tick) begin
      if ({v_abs[22:0], 1'b0} > s_q.voltage_peak_hold) begin
        s_d.voltage_peak_hold = {v_abs[22:0], 1'b0};
      end
      if (i_abs > s_q.current_peak_hold) begin
        s_d.current_peak_hold = i_abs;
      end
    end
    if (vclr) begin
      s_d.voltage_peak_hold = 24'h000000;
    end
    if (iclr) begin
      s_d.current_peak_hold = 24'h000000;
    end

    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        lsp_pkg::A_IRQ_MASK:   s_d.mask       = reg_wdata_i[15:0];
        lsp_pkg::A_TMO_RELOAD: s_d.tmo_reload = reg_wdata_i[11:0];
        lsp_pkg::A_DIP_CYC:    s_d.dip_cyc    = reg_wdata_i[7:0];
        lsp_pkg::A_DIP_LVL:    s_d.dip_lvl    = reg_wdata_i[7:0];
        lsp_pkg::A_IPK_LVL:    s_d.ipk_lvl    = reg_wdata_i[7:0];
        lsp_pkg::A_VPK_LVL:    s_d.vpk_lvl    = reg_wdata_i[7:0];
        default:               s_d.mask       = s_q.mask;
      endcase
    end

    // Register reads, data captured when the command is taken
    if (reg_rd_i) begin
      case (reg_addr_i)
        lsp_pkg::A_IRQ_MASK:   s_d.rdata = {8'h00, s_q.mask};
        lsp_pkg::A_FLAGS:      s_d.rdata = {8'h00, s_q.status};
        lsp_pkg::A_STAT_CLR:   s_d.rdata = {8'h00, s_q.status};
        lsp_pkg::A_TMO_RELOAD: s_d.rdata = {12'h000, s_q.tmo_reload};
        lsp_pkg::A_DIP_CYC:    s_d.rdata = {16'h0000, s_q.dip_cyc};
        lsp_pkg::A_DIP_LVL:    s_d.rdata = {16'h0000, s_q.dip_lvl};
        lsp_pkg::A_IPK_LVL:    s_d.rdata = {16'h0000, s_q.ipk_lvl};
        lsp_pkg::A_VPK_LVL:    s_d.rdata = {16'h0000, s_q.vpk_lvl};
        lsp_pkg::A_CURRENT_PEAK_HOLD:      s_d.rdata = s_q.current_peak_hold;
        lsp_pkg::A_CURRENT_PEAK_HOLD_CLR:  s_d.rdata = s_q.current_peak_hold;
        lsp_pkg::A_VOLTAGE_PEAK_HOLD:      s_d.rdata = s_q.voltage_peak_hold;
        lsp_pkg::A_VOLTAGE_PEAK_HOLD_CLR:  s_d.rdata = s_q.voltage_peak_hold;
        lsp_pkg::A_PERIOD:     s_d.rdata = {8'h00, s_q.period};
        default:               s_d.rdata = 24'h000000;
      endcase
    end

    // Flags: new events win over the clear of a status read
    s_d.status = s_q.status | events;
    if (stat_rd) begin
      s_d.status = events;
    end

    case (s_q.rd)
      lsp_pkg::LSP_IDLE: begin
        if (stat_rd) begin
          s_d.rd = lsp_pkg::LSP_STAT_RD;
        end
      end
      lsp_pkg::LSP_STAT_RD: begin
        if (reg_done_i) begin
          s_d.rd = lsp_pkg::LSP_IDLE;
        end
      end
      default: s_d.rd = lsp_pkg::LSP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_q            <= '0;
      s_q.rd         <= lsp_pkg::LSP_IDLE;
      s_q.tmo_cnt    <= lsp_pkg::TMO_RELOAD_RST;
      s_q.tmo_reload <= lsp_pkg::TMO_RELOAD_RST;
      s_q.dip_cyc    <= lsp_pkg::DIP_CYC_RST;
      s_q.dip_lvl    <= lsp_pkg::DIP_LVL_RST;
      s_q.dip_below  <= 1'b1;
      s_q.alert_n    <= 1'b1;
      s_q.vpk_lvl    <= lsp_pkg::PK_LVL_RST;
      s_q.ipk_lvl    <= lsp_pkg::PK_LVL_RST;
      s_q.mask       <= lsp_pkg::MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Interrupt blanked for the whole status transfer
  assign irq_n_o = (s_q.rd == lsp_pkg::LSP_STAT_RD) ? 1'b1
                   : !(|(s_q.status & s_q.mask));
  assign reg_rdata_o          = s_q.rdata;
  assign dip_alert_n_o        = s_q.alert_n;
  assign crossing_indicator_o = s_q.v_pos;
  assign energy_hold_o        = s_q.sup_sync[1];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_tmo_hold;
    (s_q.tmo_cnt == 12'h000) && !zx_ev |=> (s_q.tmo_cnt == 12'h000);
  endproperty
  a_tmo_hold: assert property (p_tmo_hold) else $error("timeout counter left zero");

  property p_reload;
    zx_ev |=> (s_q.tmo_cnt == $past(s_q.tmo_reload));
  endproperty
  a_reload: assert property (p_reload) else $error("crossing did not reload");

  property p_tmo_flag;
    tmo_ev |=> s_q.status[lsp_pkg::ST_TIMEOUT] && (s_q.tmo_cnt == 12'h000);
  endproperty
  a_tmo_flag: assert property (p_tmo_flag) else $error("timeout flag missing");

  property p_tmo_alert;
    (s_q.tmo_cnt == 12'h000) && !dip_alert_disable_i |=> !dip_alert_n_o;
  endproperty
  a_tmo_alert: assert property (p_tmo_alert) else $error("dip alert not low on timeout");

  property p_supply;
    s_q.sup_sync[1] |-> energy_hold_o ##1 !dip_alert_n_o;
  endproperty
  a_supply: assert property (p_supply) else $error("supply low not shown");

  property p_irq_blank;
    stat_rd || ((s_q.rd == lsp_pkg::LSP_STAT_RD) && !reg_done_i) |=> irq_n_o;
  endproperty
  a_irq_blank: assert property (p_irq_blank) else $error("irq low during status read");

  property p_irq_low;
    (s_q.rd == lsp_pkg::LSP_IDLE) && |(s_q.status & s_q.mask) |-> !irq_n_o;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("masked flag did not pull irq");

  property p_per_msb;
    cyc_end |=> !s_q.period[15] && s_q.per_valid;
  endproperty
  a_per_msb: assert property (p_per_msb) else $error("period msb set");

  property p_stat_clr;
    stat_rd && (events == 16'h0000) |=> (s_q.status == 16'h0000) && irq_n_o;
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("status not cleared by read");

  property p_pending;
    (s_q.rd == lsp_pkg::LSP_STAT_RD) && (events != 16'h0000) |=> (s_q.status != 16'h0000);
  endproperty
  a_pending: assert property (p_pending) else $error("pending event lost");

  property p_voltage_peak_hold_mono;
    pk_tick && !vclr |=> (s_q.voltage_peak_hold >= $past(s_q.voltage_peak_hold));
  endproperty
  a_voltage_peak_hold_mono: assert property (p_voltage_peak_hold_mono) else $error("voltage peak hold fell");

  property p_peak_clr;
    iclr |=> (s_q.current_peak_hold == 24'h000000);
  endproperty
  a_peak_clr: assert property (p_peak_clr) else $error("current peak not cleared");

  property p_cross_flag;
    zx_ev |=> s_q.status[lsp_pkg::ST_CROSS];
  endproperty
  a_cross_flag: assert property (p_cross_flag) else $error("crossing flag missing");

  property p_dip_flag;
    dip_ev |=> s_q.status[lsp_pkg::ST_DIP] && s_q.dip_alert;
  endproperty
  a_dip_flag: assert property (p_dip_flag) else $error("dip flag missing");

  property p_vpk_flag;
    vpk_ev |=> s_q.status[lsp_pkg::ST_VPK];
  endproperty
  a_vpk_flag: assert property (p_vpk_flag) else $error("voltage peak flag missing");

  property p_ipk_flag;
    ipk_ev |=> s_q.status[lsp_pkg::ST_IPK];
  endproperty
  a_ipk_flag: assert property (p_ipk_flag) else $error("current peak flag missing");

  property p_dip_release;
    s_q.dip_alert && sample_valid_i && (v_dip_byte > s_q.dip_lvl) |=> !s_q.dip_alert;
  endproperty
  a_dip_release: assert property (p_dip_release) else $error("dip alert not released");

  c_timeout:  cover property (tmo_ev);
  c_dip:      cover property (dip_ev ##1 !dip_alert_n_o);
  c_stat_rd:  cover property (stat_rd ##[1:40] reg_done_i);
  c_vpk_flag: cover property (vpk_ev ##1 s_q.status[lsp_pkg::ST_VPK]);
endmodule : lsp_line_supervisor
`default_nettype wire

//--- src/lsp_pkg.sv
// Constants shared by the line supervisor block
package lsp_pkg;
  // Register map, six-bit address space
  localparam int unsigned        ADDR_W         = 6;
  localparam logic [ADDR_W-1:0]  A_IRQ_MASK     = 6'h0a;
  localparam logic [ADDR_W-1:0]  A_FLAGS        = 6'h0b;
  localparam logic [ADDR_W-1:0]  A_STAT_CLR     = 6'h0c;
  localparam logic [ADDR_W-1:0]  A_TMO_RELOAD   = 6'h1d;
  localparam logic [ADDR_W-1:0]  A_DIP_CYC      = 6'h1e;
  localparam logic [ADDR_W-1:0]  A_DIP_LVL      = 6'h1f;
  localparam logic [ADDR_W-1:0]  A_IPK_LVL      = 6'h20;
  localparam logic [ADDR_W-1:0]  A_VPK_LVL      = 6'h21;
  localparam logic [ADDR_W-1:0]  A_CURRENT_PEAK_HOLD        = 6'h22;
  localparam logic [ADDR_W-1:0]  A_CURRENT_PEAK_HOLD_CLR    = 6'h23;
  localparam logic [ADDR_W-1:0]  A_VOLTAGE_PEAK_HOLD        = 6'h24;
  localparam logic [ADDR_W-1:0]  A_VOLTAGE_PEAK_HOLD_CLR    = 6'h25;
  localparam logic [ADDR_W-1:0]  A_PERIOD       = 6'h27;

  // Flag positions in the 16-bit status word
  localparam int unsigned        ST_TIMEOUT     = 1;
  localparam int unsigned        ST_DIP         = 3;
  localparam int unsigned        ST_CROSS       = 4;
  localparam int unsigned        ST_IPK         = 7;
  localparam int unsigned        ST_VPK         = 8;

  // Reset values
  localparam logic [11:0]        TMO_RELOAD_RST = 12'hfff;
  localparam logic [7:0]         DIP_CYC_RST    = 8'h04;
  localparam logic [7:0]         DIP_LVL_RST    = 8'h00;
  localparam logic [7:0]         PK_LVL_RST     = 8'hff;
  localparam logic [15:0]        MASK_RST       = 16'h0000;

  // Timing: master clock cycles per step
  localparam int unsigned        TMO_DIV        = 128;
  localparam int unsigned        PEAK_DIV       = 4;
  // Period = cycles * 16 / (4 * 32)
  localparam int unsigned        PER_SHIFT      = 3;
  // Averaging weight 1/2^k of the period filter
  localparam int unsigned        PER_FILT_K     = 3;

  typedef enum logic [1:0] {
    LSP_IDLE    = 2'b01,
    LSP_STAT_RD = 2'b10
  } lsp_rd_t;
endpackage : lsp_pkg

//--- tb/lsp_host_model.sv
// Host model that drives the register port of the line supervisor
`timescale 1ns/1ps
`default_nettype none
module lsp_host_model (
  input  wire logic                       ref_clk_i,
  input  wire logic [23:0]                reg_rdata_i,
  output var  logic [lsp_pkg::ADDR_W-1:0] reg_addr_o,
  output var  logic                       reg_wr_o,
  output var  logic [23:0]                reg_wdata_o,
  output var  logic                       reg_rd_o,
  output var  logic                       reg_done_o
);
  initial begin
    reg_addr_o  = 6'h3f;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 24'h000000;
    reg_rd_o    = 1'b0;
    reg_done_o  = 1'b0;
  end

  task automatic wr(input logic [lsp_pkg::ADDR_W-1:0] a, input logic [23:0] d);
    @(posedge ref_clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o    <= 1'b0;
    // Released data shows the inverse, never a stale copy
    reg_wdata_o <= ~d;
  endtask : wr

  // Address held until done, so clear-on-read targets see it
  task automatic rd(input logic [lsp_pkg::ADDR_W-1:0] a, output logic [23:0] d,
                    input int gap);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o   <= 1'b0;
    #1;
    d = reg_rdata_i;
    repeat (gap) @(posedge ref_clk_i);
    reg_done_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_done_o <= 1'b0;
  endtask : rd

  // Interrupt source taken from the clear-on-read status only
  task automatic stat(output logic [23:0] d, input int gap);
    rd(lsp_pkg::A_STAT_CLR, d, gap);
  endtask : stat
endmodule : lsp_host_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the line supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                       ref_clk_i   = 1'b0;
  logic                       rst_i       = 1'b1;
  logic [15:0]                v_filt      = 16'h0000;
  logic [23:0]                v_smp       = 24'h000000;
  logic [23:0]                i_smp       = 24'h000000;
  logic                       smp_valid   = 1'b0;
  logic                       supply_low  = 1'b0;
  logic                       dip_dis     = 1'b0;
  logic [lsp_pkg::ADDR_W-1:0] reg_addr;
  logic                       reg_wr;
  logic [23:0]                reg_wdata;
  logic                       reg_rd;
  logic                       reg_done;
  logic [23:0]                reg_rdata;
  logic                       irq_n;
  logic                       dip_alert_n;
  logic                       cross_ind;
  logic                       energy_hold;
  logic [23:0]                rd_val;
  int                         k;
  int                         err_count   = 0;
  int                         num_checks  = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  // Short timeout step keeps the crossing-loss test brief
  lsp_line_supervisor #(.TMO_DIV(4), .PEAK_DIV(lsp_pkg::PEAK_DIV)) lsp_line_supervisor_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .v_filt_i(v_filt), .v_sample_i(v_smp),
    .i_sample_i(i_smp), .sample_valid_i(smp_valid), .supply_low_i(supply_low),
    .dip_alert_disable_i(dip_dis), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_done_i(reg_done),
    .reg_rdata_o(reg_rdata), .irq_n_o(irq_n), .dip_alert_n_o(dip_alert_n),
    .crossing_indicator_o(cross_ind), .energy_hold_o(energy_hold));

  lsp_host_model lsp_host_model_inst (
    .ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .reg_done_o(reg_done));

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chb(input logic got, input logic exp);
    chk({23'h0, got}, {23'h0, exp});
  endtask : chb

  task automatic wr(input logic [lsp_pkg::ADDR_W-1:0] a, input logic [23:0] d);
    lsp_host_model_inst.wr(a, d);
    #1;
  endtask : wr

  task automatic rdc(input logic [lsp_pkg::ADDR_W-1:0] a, input logic [23:0] m,
                     input logic [23:0] exp);
    lsp_host_model_inst.rd(a, rd_val, 1);
    #1;
    chk(rd_val & m, exp);
  endtask : rdc

  task automatic smp(input logic [15:0] f, input logic [23:0] v, input logic [23:0] i);
    @(posedge ref_clk_i);
    v_filt    <= f;
    v_smp     <= v;
    i_smp     <= i;
    smp_valid <= 1'b1;
    @(posedge ref_clk_i);
    smp_valid <= 1'b0;
    #1;
  endtask : smp

  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rdc(lsp_pkg::A_TMO_RELOAD, 24'hffffff, 24'h000fff);
    rdc(lsp_pkg::A_IRQ_MASK, 24'hffffff, 24'h000000);
    rdc(6'h3f, 24'hffffff, 24'h000000);
    wr(lsp_pkg::A_TMO_RELOAD, 24'hfffabc);
    rdc(lsp_pkg::A_TMO_RELOAD, 24'hffffff, 24'h000abc);
    wr(lsp_pkg::A_TMO_RELOAD, 24'h000008);
    smp(16'he000, 24'h0, 24'h0);
    smp(16'h2000, 24'h0, 24'h0);
    chb(cross_ind, 1'b1);
    repeat (20) @(posedge ref_clk_i);
    #1;
    chb(dip_alert_n, 1'b1);
    for (k = 0; k < 40 && dip_alert_n !== 1'b0; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chb(dip_alert_n, 1'b0);
    if (k == 40) final_report();
    chb(irq_n, 1'b1);
    rdc(lsp_pkg::A_FLAGS, 24'h000012, 24'h000012);
    wr(lsp_pkg::A_IRQ_MASK, 24'h000002);
    chb(irq_n, 1'b0);
    rdc(lsp_pkg::A_STAT_CLR, 24'h000012, 24'h000012);
    chb(irq_n, 1'b1);
    rdc(lsp_pkg::A_STAT_CLR, 24'h000002, 24'h000000);
    @(posedge ref_clk_i);
    dip_dis <= 1'b1;
    smp(16'he000, 24'h0, 24'h0);
    smp(16'h2000, 24'h0, 24'h0);
    chb(dip_alert_n, 1'b1);
    repeat (60) @(posedge ref_clk_i);
    #1;
    chb(dip_alert_n, 1'b1);
    rdc(lsp_pkg::A_STAT_CLR, 24'h000002, 24'h000002);
    wr(lsp_pkg::A_TMO_RELOAD, 24'h000fff);
    wr(lsp_pkg::A_IRQ_MASK, 24'h000008);
    wr(lsp_pkg::A_DIP_LVL, 24'h000040);
    // Level equal to sample byte must not count as a dip
    smp(16'he000, 24'h0, 24'h0);
    smp(16'h2000, 24'h0, 24'h0);
    @(posedge ref_clk_i);
    dip_dis <= 1'b0;
    smp(16'h2000, 24'h0, 24'h0);
    for (int n = 1; n <= 4; n++) begin
      smp(16'hff00, 24'h0, 24'h0);
      smp(16'h0100, 24'h0, 24'h0);
      repeat (2) @(posedge ref_clk_i);
      #1;
      chb(dip_alert_n, n != 4);
    end
    chb(irq_n, 1'b0);
    rdc(lsp_pkg::A_STAT_CLR, 24'h000008, 24'h000008);
    smp(16'h2100, 24'h0, 24'h0);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chb(dip_alert_n, 1'b1);
    wr(lsp_pkg::A_VPK_LVL, 24'h000010);
    wr(lsp_pkg::A_IPK_LVL, 24'h000010);
    wr(lsp_pkg::A_IRQ_MASK, 24'h000100);
    smp(16'h2000, 24'h088000, 24'hfc0000);
    rdc(lsp_pkg::A_STAT_CLR, 24'h000180, 24'h000100);
    smp(16'h2000, 24'h088000, 24'h090000);
    rdc(lsp_pkg::A_STAT_CLR, 24'h000180, 24'h000180);
    smp(16'h2000, 24'h0, 24'h0);
    rdc(lsp_pkg::A_VOLTAGE_PEAK_HOLD, 24'hffffff, 24'h110000);
    rdc(lsp_pkg::A_VOLTAGE_PEAK_HOLD_CLR, 24'hffffff, 24'h110000);
    rdc(lsp_pkg::A_VOLTAGE_PEAK_HOLD, 24'hffffff, 24'h000000);
    rdc(lsp_pkg::A_CURRENT_PEAK_HOLD, 24'hffffff, 24'h090000);
    rdc(lsp_pkg::A_CURRENT_PEAK_HOLD_CLR, 24'hffffff, 24'h090000);
    rdc(lsp_pkg::A_CURRENT_PEAK_HOLD, 24'hffffff, 24'h000000);
    fork
      lsp_host_model_inst.stat(rd_val, 8);
      begin
        repeat (3) @(posedge ref_clk_i);
        smp(16'h2000, 24'h088000, 24'h0);
        for (int n = 0; n < 4; n++) begin
          @(posedge ref_clk_i);
          #1;
          chb(irq_n, 1'b1);
        end
      end
    join
    #1;
    chb(irq_n, 1'b0);
    chk(rd_val & 24'h000100, 24'h000000);
    rdc(lsp_pkg::A_STAT_CLR, 24'h000100, 24'h000100);
    // Enough cycles for the averaging filter to settle
    for (int n = 0; n < 32; n++) begin
      smp(16'hc000, 24'h0, 24'h0);
      repeat (198) @(posedge ref_clk_i);
      smp(16'h4000, 24'h0, 24'h0);
      repeat (198) @(posedge ref_clk_i);
    end
    // Rising crossings 400 cycles apart give 400 >> 3
    rdc(lsp_pkg::A_PERIOD, 24'h008000, 24'h000000);
    chb(rd_val >= 24'd49 && rd_val <= 24'd51, 1'b1);
    @(posedge ref_clk_i);
    supply_low <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    chb(energy_hold, 1'b1);
    chb(dip_alert_n, 1'b0);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
